/* src/sar_adc_serial_port.sv */
`timescale 1ns/1ps
// Function
// - falling chip select starts a conversion frame
// - conversions repeat while chip select stays low; raising it ends them
// - control bits from serial input are captured on rising serial clock edges
// - result bits advance on serial output at each falling serial clock edge
// - all sequencing is counted from serial clock edges only
// - result is 12-bit unsigned straight binary, zero at range bottom
// - one of eight input channels is selected for conversion
// - host keeps throughput between 50 kSPS and 1 MSPS
// - chip select high is power-down; conversion activity stops
module sar_adc_serial_port
	import sasp_pkg::*;
#(
	parameter int NUM_CH = sasp_pkg::NUM_CHAN
) (
	input  wire logic                          clk,
	input  wire logic                          rst_b,
	input  wire logic                          chipSel_b,
	input  wire logic                          serClk,
	input  wire logic                          serIn,
	output logic                               serOut,
	output logic                               serOutEn_b,
	output logic [sasp_pkg::CHAN_W-1:0]        convChan,
	output logic                               sampleTrack,
	output logic                               convStart,
	input  wire logic [sasp_pkg::RESULT_W-1:0] convResult,
	output logic                               powerDown
);
	import sasp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser: nothing reads the raw pins
	logic [2:0] pinSync;

	sasp_sync #(
		.WIDTH (3)
	) u_sync (
		.clk     (clk),
		.rst_b   (rst_b),
		.asyncIn ({chipSel_b, serClk, serIn}),
		.syncOut (pinSync)
	);

	logic csS;
	logic sckS;
	logic dinS;
	assign csS  = pinSync[2];
	assign sckS = pinSync[1];
	assign dinS = pinSync[0];

	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		sasp_mode_t            mode;
		logic                  csPrev;
		logic                  sckPrev;
		logic [CNT_W-1:0]      bitCnt;
		logic [CHAN_W-1:0]     ctrlShift;
		logic [CHAN_W-1:0]     chan;
		logic [RESULT_W-1:0]   outShift;
		logic                  dout;
		logic                  doutEn_b;
		logic                  start;
	} sasp_state_t;

	sasp_state_t s_q;
	sasp_state_t s_d;

	logic csFall;
	logic sckRise;
	logic sckFall;

	// address window of the control word, in falling-clock counts
	function automatic logic addrWin(input logic [CNT_W-1:0] cnt);
		return cnt >= CNT_W'(ADDR_MSB_CYC) && cnt < CNT_W'(ADDR_MSB_CYC + CHAN_W);
	endfunction : addrWin

	always_comb begin
		csFall  = s_q.csPrev & ~csS;
		sckRise = ~s_q.sckPrev & sckS;
		sckFall = s_q.sckPrev & ~sckS;
		s_d         = s_q;
		s_d.csPrev  = csS;
		s_d.sckPrev = sckS;
		s_d.start   = 1'b0;
		unique case (s_q.mode)
			SASP_DOWN: begin
				s_d.doutEn_b = 1'b1;
				s_d.dout     = 1'b0;
				if (csFall) begin
					s_d.mode     = SASP_FRAME;
					s_d.bitCnt   = '0;
					s_d.doutEn_b = 1'b0;
					s_d.start    = 1'b1;
					s_d.outShift = convResult;
				end
			end
			SASP_FRAME: begin
				if (csS) begin
					s_d.mode     = SASP_DOWN;
					s_d.doutEn_b = 1'b1;
					s_d.dout     = 1'b0;
				end else begin
					if (sckRise) begin
						// address bits sit in counts 2..4 of the control word
						if (addrWin(s_q.bitCnt)) begin
							s_d.ctrlShift = {s_q.ctrlShift[CHAN_W-2:0], dinS};
						end
					end
					if (sckFall) begin
						s_d.bitCnt = s_q.bitCnt + 1'b1;
						if (s_q.bitCnt == CNT_LAST) begin
							// new frame: channel picked last frame is converted now
							s_d.chan     = s_q.ctrlShift;
							s_d.start    = 1'b1;
							s_d.outShift = convResult;
							s_d.dout     = 1'b0;
						end else if (s_q.bitCnt >= CNT_W'(LEAD_ZEROS - 1)) begin
							s_d.dout     = s_q.outShift[RESULT_W-1];
							s_d.outShift = {s_q.outShift[RESULT_W-2:0], 1'b0};
						end else begin
							s_d.dout = 1'b0;
						end
					end
				end
			end
			default: begin
				s_d.mode = SASP_DOWN;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_q.mode      <= SASP_DOWN;
			// synced pins read low in reset; a high previous value would fake a fall
			s_q.csPrev    <= 1'b0;
			s_q.sckPrev   <= 1'b0;
			s_q.bitCnt    <= '0;
			s_q.ctrlShift <= CHAN_RST;
			s_q.chan      <= CHAN_RST;
			s_q.outShift  <= RESULT_RST;
			s_q.dout      <= 1'b0;
			s_q.doutEn_b  <= 1'b1;
			s_q.start     <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign serOut      = s_q.dout;
	assign serOutEn_b  = s_q.doutEn_b;
	assign convChan    = s_q.chan;
	assign convStart   = s_q.start;
	assign powerDown   = (s_q.mode == SASP_DOWN);
	// track during the first clocks of each frame
	assign sampleTrack = (s_q.mode == SASP_FRAME) && (s_q.bitCnt < CNT_W'(TRACK_CYC));

	////////////////////////////////////////////////////////////////////////
	a_start_on_fall: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_DOWN && s_q.csPrev && !csS) |=> (s_q.mode == SASP_FRAME && convStart))
		else $error("no frame start after chip select fall");
	a_stop_on_high: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_FRAME && csS) |=> (powerDown && serOutEn_b))
		else $error("frame not ended by chip select high");
	a_down_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		powerDown && $past(powerDown) |-> !convStart && serOutEn_b)
		else $error("activity while powered down");
	a_out_on_fall: assert property (@(posedge clk) disable iff (!rst_b)
		$changed(serOut) && !serOutEn_b && $past(!serOutEn_b) |-> $past(sckFall))
		else $error("serial output moved without a falling clock");
	a_count_on_fall: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_FRAME && !csS && !sckFall) |=> $stable(s_q.bitCnt))
		else $error("bit counter moved without a clock edge");
	a_lead_zeros: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_FRAME && s_q.bitCnt <= CNT_W'(LEAD_ZEROS - 1)
			&& s_q.bitCnt != '0) |-> !serOut)
		else $error("leading bit not zero");
	a_repeat_frame: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_FRAME && !csS && sckFall && s_q.bitCnt == CNT_LAST)
			|=> convStart && s_q.bitCnt == '0)
		else $error("next conversion not started at frame end");
	a_msb_first: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_FRAME && !csS && sckFall && s_q.bitCnt == CNT_W'(LEAD_ZEROS - 1))
			|=> serOut == $past(s_q.outShift[RESULT_W-1]))
		else $error("result not sent msb first");
	a_ctrl_capture: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_FRAME && !csS && sckRise && s_q.bitCnt == CNT_W'(ADDR_MSB_CYC))
			|=> s_q.ctrlShift[0] == $past(dinS))
		else $error("control bit not captured on rising clock");
	a_chan_latch: assert property (@(posedge clk) disable iff (!rst_b)
		convStart && $past(s_q.mode) == SASP_FRAME |-> convChan == $past(s_q.ctrlShift))
		else $error("channel not taken from control word");
	a_start_pulse: assert property (@(posedge clk) disable iff (!rst_b)
		convStart |=> !convStart)
		else $error("conversion start longer than one cycle");
	a_frame_zero: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_FRAME && !csS && sckFall && s_q.bitCnt == CNT_LAST)
			|=> !serOut)
		else $error("no leading zero at frame restart");
	a_shift_step: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_FRAME && !csS && sckFall
			&& s_q.bitCnt > CNT_W'(LEAD_ZEROS - 1) && s_q.bitCnt != CNT_LAST)
			|=> serOut == $past(s_q.outShift[RESULT_W-1]))
		else $error("result bit out of order");
	a_chan_hold: assert property (@(posedge clk) disable iff (!rst_b)
		$changed(convChan) |-> convStart)
		else $error("channel moved inside a frame");
	a_drive_in_frame: assert property (@(posedge clk) disable iff (!rst_b)
		!powerDown |-> !serOutEn_b)
		else $error("output not driven during a frame");
	a_track_start: assert property (@(posedge clk) disable iff (!rst_b)
		convStart |-> sampleTrack)
		else $error("no track phase at conversion start");
	a_addr_window: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_FRAME && !csS && sckRise && !addrWin(s_q.bitCnt))
			|=> $stable(s_q.ctrlShift))
		else $error("control bit taken outside the address window");
	a_count_step: assert property (@(posedge clk) disable iff (!rst_b)
		(s_q.mode == SASP_FRAME && !csS && sckFall)
			|=> s_q.bitCnt == $past(s_q.bitCnt) + 1'b1)
		else $error("bit counter skipped a falling clock");
endmodule : sar_adc_serial_port

/* inc/sasp_pkg.sv */
package sasp_pkg;
	localparam int RESULT_W     = 12;
	localparam int FRAME_CYC    = 16;
	localparam int CNT_W        = 4;
	localparam int CHAN_W       = 3;
	localparam int NUM_CHAN     = 8;
	localparam int LEAD_ZEROS   = FRAME_CYC - RESULT_W;
	localparam int ADDR_MSB_CYC = 2;
	localparam int TRACK_CYC    = 3;
	localparam logic [CNT_W-1:0] CNT_LAST = 4'hf;
	localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
	localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

	typedef enum logic [1:0] {
		SASP_DOWN  = 2'b00,
		SASP_FRAME = 2'b01
	} sasp_mode_t;
endpackage : sasp_pkg

/* src/sasp_sync.sv */
`timescale 1ns/1ps
module sasp_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} sasp_sync_t;

	sasp_sync_t state_q;
	sasp_sync_t state_d;

	always_comb begin
		state_d.meta   = asyncIn;
		state_d.stable = state_q.meta;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign syncOut = state_q.stable;
endmodule : sasp_sync

/* testbench/sasp_host.sv */
`timescale 1ns/1ps
module sasp_host (
	input  wire logic        clk,
	input  wire logic        serOut,
	output logic             chipSel_b,
	output logic             serClk,
	output logic             serIn,
	output logic [11:0]      conv
);
	initial begin
		chipSel_b = 1'b1;
		serClk = 1'b1;
		serIn = 1'b0;
		conv = 12'h000;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic sel(input logic v, input logic [11:0] r);
		conv = r;
		chipSel_b = v;
		tick(10);
	endtask : sel
	// 80 ns clock and 16 clocks a frame keep rate and throughput legal
	task automatic frame(input logic [2:0] ch, input logic [11:0] nxt, output logic [15:0] w);
		for (int k = 0; k < 16; k++) begin
			w[15-k] = serOut; // taken before the fall; device lags by clocks
			if (k == 15) begin
				conv = nxt;
			end
			serClk = 1'b0;
			// the rise after fall k is taken at count k+1: address rides clocks 1..3
			serIn = (k >= 1 && k <= 3) ? ch[3-k] : k[0];
			tick(10);
			serClk = 1'b1;
			tick(10);
		end
		serIn = ~serIn; // released line never keeps the last value
	endtask : frame
endmodule : sasp_host

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	import sasp_pkg::*;
	logic                clk = 1'b0;
	logic                rst_b = 1'b0;
	logic                chipSel_b, serClk, serIn, serOut, serOutEn_b;
	logic                sampleTrack, convStart, powerDown;
	logic [CHAN_W-1:0]   convChan;
	logic [RESULT_W-1:0] convResult;
	logic [15:0]         w;
	int                  fails = 0;
	int                  checks_done = 0;
	int                  starts = 0;
	always #2 clk = ~clk;
	// start pulses counted off the edge so the count never races the design
	always @(negedge clk) begin
		if (convStart === 1'b1) begin
			starts++;
		end
	end
	sar_adc_serial_port dut (.clk(clk), .rst_b(rst_b), .chipSel_b(chipSel_b), .serClk(serClk),
		.serIn(serIn), .serOut(serOut), .serOutEn_b(serOutEn_b), .convChan(convChan),
		.sampleTrack(sampleTrack), .convStart(convStart), .convResult(convResult),
		.powerDown(powerDown));
	sasp_host host (.clk(clk), .serOut(serOut), .chipSel_b(chipSel_b), .serClk(serClk),
		.serIn(serIn), .conv(convResult));
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : cmp
	task automatic test_done();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done
	// bounded wait on the standby flag
	task automatic wait_pd(input logic v);
		int n;
		n = 0;
		while (powerDown !== v && n < 10) begin
			host.tick(1);
			n++;
		end
		if (powerDown !== v) begin
			fails++;
			$display("Error %0t: standby flag timeout", $time);
			test_done();
		end
	endtask : wait_pd
	task automatic t_single();
		int s0;
		s0 = starts;
		host.sel(1'b0, 12'hfff);
		wait_pd(1'b0);
		cmp(16'(serOutEn_b), 16'h0000, "enable");
		cmp(16'(sampleTrack), 16'h0001, "track");
		host.frame(3'h5, 12'hfff, w);
		cmp(w, 16'h0fff, "word");
		host.sel(1'b1, 12'h000);
		wait_pd(1'b1);
		cmp(16'(convChan), 16'h0005, "chan");
		cmp(16'(serOutEn_b), 16'h0001, "off");
		cmp(16'(sampleTrack), 16'h0000, "track off");
		cmp(16'(starts - s0), 16'h0002, "starts");
		$display("test single done");
	endtask : t_single
	// one select held over eight frames, every channel, full code range
	task automatic t_stream();
		int s0;
		s0 = starts;
		host.sel(1'b0, 12'h000);
		wait_pd(1'b0);
		for (int i = 0; i < 8; i++) begin
			host.frame(3'(i), 12'(12'h249 * (i + 1)), w);
			cmp(w, 16'(12'h249 * i), "stream");
			cmp(16'(convChan), 16'(i), "chan");
			cmp(16'(powerDown), 16'h0000, "busy");
			cmp(16'(sampleTrack), 16'h0001, "track");
		end
		host.sel(1'b1, 12'h000);
		wait_pd(1'b1);
		cmp(16'(starts - s0), 16'h0009, "starts");
		$display("test stream done");
	endtask : t_stream
	initial begin
		host.tick(6);
		rst_b = 1'b1;
		host.tick(4);
		cmp(16'(powerDown), 16'h0001, "rst");
		cmp(16'(convStart), 16'h0000, "rst");
		cmp(16'(starts), 16'h0000, "rst starts");
		t_single();
		t_stream();
		test_done();
	end
endmodule : tb_top
